// file: wpss_asserts.sv
// Port checks for the word program host controller.
// Assumes a bind onto wpss_host with clk_en held high.
`timescale 1ns/100ps
module wpss_asserts #(
  parameter int ADDR_W = 23,
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic              ref_clk,
  input wire logic              sys_rst,
  // Device pins
  input wire logic              mem_ce_n,
  input wire logic              mem_we_n,
  input wire logic              mem_oe_n,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [DATA_W-1:0] mem_dq_out,
  input wire logic              mem_dq_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_we_in_ce: assert property (!mem_we_n |-> !mem_ce_n)
    else $error("write strobe outside chip enable");
  a_we_width: assert property ($fell(mem_we_n) |-> (!mem_we_n)[*8] ##1 (!mem_we_n)[*3] ##1 mem_we_n)
    else $error("write pulse not eleven cycles");
  a_we_gap: assert property ($rose(mem_we_n) |-> mem_we_n[*4])
    else $error("write recovery too short");
  a_dq_held: assert property (!mem_we_n && !$past(mem_we_n) |-> mem_dq_oe && $stable(mem_dq_out))
    else $error("write data moved inside pulse");
  a_addr_same: assert property ($rose(mem_we_n) |-> $stable(mem_addr)[*4])
    else $error("address moved after write");
  a_read_clean: assert property (!mem_oe_n |-> mem_we_n && !mem_dq_oe && !mem_ce_n)
    else $error("status read with bus contention");
  a_oe_width: assert property ($fell(mem_oe_n) |-> (!mem_oe_n)[*8])
    else $error("status read too short");
  a_poll_gap: assert property ($rose(mem_oe_n) |-> mem_oe_n[*4])
    else $error("poll gap too short");
  c_write: cover property ($rose(mem_we_n));
  c_poll: cover property ($rose(mem_oe_n) ##[1:8] $fell(mem_oe_n));
  c_drive: cover property (mem_dq_oe);
endmodule : wpss_asserts
bind wpss_host wpss_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .mem_ce_n(mem_ce_n), .mem_we_n(mem_we_n),
  .mem_oe_n(mem_oe_n), .mem_addr(mem_addr), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe));

// file: wpss_dev_model.sv
// Behavioural phase-change memory: word program, status, clear, read array.
// Assumes host pins as one struct and fault inputs from the bench.
`timescale 1ns/100ps
module wpss_dev_model #(
  parameter int          PROG_NS  = 2000,
  parameter logic [15:0] ARR_WORD = 16'h96A5
) (
  // Host pins
  input  wire wpss_pkg::wpss_pins_t pins,
  output logic [15:0]               dq_in,
  // Fault injection
  input  wire logic                 vpp_bad,
  input  wire logic                 lock,
  input  wire logic                 wfail,
  // Observation
  output logic [7:0]                sr,
  output logic [15:0]               scode,
  output logic [15:0]               wdata,
  output logic [22:0]               waddr,
  output logic                      arr_mode,
  output int                        nprog
);
  import wpss_pkg::*;
  logic        in_setup;
  logic [15:0] rd_last;
  wire         rd_on  = !pins.ce_n && !pins.oe_n;
  wire  [15:0] rd_val = arr_mode ? ARR_WORD : {8'h00, sr};
  // Released bus shows the inverse of the last word, so a stale sample is caught
  assign dq_in = pins.dq_oe ? pins.dq_out : (rd_on ? rd_val : ~rd_last);
  always @(negedge rd_on) rd_last = rd_val;
  initial begin
    sr = 8'h80;
    in_setup = 1'b0;
    arr_mode = 1'b1;
    nprog = 0;
    rd_last = 16'h0000;
  end
  always @(posedge pins.we_n) begin
    if (!pins.ce_n && in_setup) begin
      in_setup = 1'b0;
      waddr = pins.addr;
      wdata = dq_in;
      if (sr[3] || vpp_bad) begin
        sr[3] = 1'b1;
      end else if (lock) begin
        sr[1] = 1'b1;
      end else begin
        nprog++;
        sr[7] = 1'b0;
        sr[7] <= #PROG_NS 1'b1;
        sr[4] <= #PROG_NS (wfail | sr[4]);
      end
    end else if (!pins.ce_n) begin
      case (dq_in[7:0])
        8'h40, 8'h42: begin
          in_setup = 1'b1;
          scode = dq_in;
          arr_mode = 1'b0;
        end
        8'h50: sr = sr & 8'hE5;
        8'hFF: arr_mode = 1'b1;
        default: ;
      endcase
    end
  end
endmodule : wpss_dev_model

// file: wpss_host.sv
// Host controller that programs single words into a parallel phase-change memory.
// Assumes software on Avalon-MM with waitrequest and a device on its asynchronous pins.
//
// Overview of operation
// - Start each word write with a setup write of 40h or 42h at target.
// - Follow setup directly with the data write at the same location.
// - During programming each read returns fresh status; poll ready until it is one.
// - After the last write, write FFh to return the device to array read.
// - Host may check errors per word or once after a series.
// - On any error, clear status before retrying or other recovery.
// - Nominal 500 us erase to suspend spacing, not needed by this memory.
`timescale 1ns/100ps
`include "wpss_map.svh"

module wpss_host #(
  parameter int          ADDR_W  = 23,
  parameter int          DATA_W  = 16,
  parameter logic [31:0] TIMEOUT = `WPSS_TMO_DEF
) (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                sys_rst,
  input  wire logic                clk_en,
  // Avalon-MM slave
  input  wire logic [3:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  output logic                     irq,
  // Device pins
  output logic                     mem_ce_n,
  output logic                     mem_we_n,
  output logic                     mem_oe_n,
  output logic      [ADDR_W-1:0]   mem_addr,
  output logic      [DATA_W-1:0]   mem_dq_out,
  output logic                     mem_dq_oe,
  input  wire logic [DATA_W-1:0]   mem_dq_in
);
  import wpss_pkg::*;

  // ----------------------------------------
  // Timing counts
  // ----------------------------------------
  // Least times round up to whole cycles
  localparam int WE_LOW_CYC  = (`WPSS_WE_LOW_NS + `WPSS_CLK_NS - 1) / `WPSS_CLK_NS;
  localparam int WE_HIGH_CYC = (`WPSS_WE_HIGH_NS + `WPSS_CLK_NS - 1) / `WPSS_CLK_NS;
  // Two extra cycles cover the input synchroniser
  localparam int RD_CYC      = (`WPSS_RD_NS + `WPSS_CLK_NS - 1) / `WPSS_CLK_NS + 2;

  function automatic logic [7:0] cyc8(input int n);
    cyc8 = n[7:0];
  endfunction : cyc8

  // ----------------------------------------
  // State
  // ----------------------------------------
  wpss_state_t          state_reg, state_next;
  logic [7:0]           tick_reg;
  logic                 phase_reg;
  logic [31:0]          wait_reg;
  logic [ADDR_W-1:0]    addr_reg;
  logic [DATA_W-1:0]    data_reg;
  logic                 bitalt_reg;
  logic [7:0]           dev_sr_reg;
  logic [7:0]           stat_reg;
  logic [2:0]           irq_stat_reg, irq_mask_reg;
  logic                 busy_reg;
  logic                 timeout_reg;
  logic [DATA_W-1:0]    dq_s1_reg, dq_s2_reg;
  wpss_pins_t           pins_reg;
  logic [31:0]          rdata_reg;
  logic                 wait_n_reg;
  logic                 irq_reg;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire       acc      = (avs_read | avs_write) & ~wait_n_reg;
  // Writes land at the edge where the master samples waitrequest low
  wire       wr       = avs_write & wait_n_reg;
  wire       wr_ctrl  = wr & (avs_address == `WPSS_OFF_CTRL);
  wire       wr_addr  = wr & (avs_address == `WPSS_OFF_ADDR) & ~busy_reg;
  wire       wr_data  = wr & (avs_address == `WPSS_OFF_DATA) & ~busy_reg;
  wire       wr_ist   = wr & (avs_address == `WPSS_OFF_IRQ_STAT);
  wire       wr_imsk  = wr & (avs_address == `WPSS_OFF_IRQ_MASK);
  // Only word writes, clear and read array go out; no erase or suspend, so no spacing to
  wire       cmd_go   = wr_ctrl & avs_writedata[`WPSS_CTRL_GO] & ~busy_reg;
  wire       cmd_clr  = wr_ctrl & avs_writedata[`WPSS_CTRL_CLEAR] & ~busy_reg;
  wire       cmd_arr  = wr_ctrl & avs_writedata[`WPSS_CTRL_ARRAY] & ~busy_reg;
  wire       any_err  = dev_sr_reg[`WPSS_SR_SUPPLY_ERR] | dev_sr_reg[`WPSS_SR_WRITE_ERR]
                      | dev_sr_reg[`WPSS_SR_LOCKED];
  // Host keeps no retry going over a standing error
  wire       go_block = any_err;
  wire       tick_end = (tick_reg == 8'h00);
  wire [7:0] rd_sr    = dq_s2_reg[7:0];
  wire       rd_ready = rd_sr[`WPSS_SR_READY];

  logic [31:0] rmux;
  always_comb begin
    case (avs_address)
      `WPSS_OFF_CTRL:     rmux = {31'h0, busy_reg};
      `WPSS_OFF_ADDR:     rmux = 32'(addr_reg);
      `WPSS_OFF_DATA:     rmux = 32'(data_reg);
      `WPSS_OFF_STAT:     rmux = {23'h0, timeout_reg, stat_reg};
      `WPSS_OFF_IRQ_STAT: rmux = {29'h0, irq_stat_reg};
      `WPSS_OFF_IRQ_MASK: rmux = {29'h0, irq_mask_reg};
      `WPSS_OFF_DEV_SR:   rmux = {24'h0, dev_sr_reg};
      default:            rmux = 32'h0;
    endcase
  end

  // ----------------------------------------
  // Sequencer next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      WPSS_IDLE: begin
        if (cmd_go && !go_block)
          state_next = WPSS_SETUP;
        else if (cmd_clr)
          state_next = WPSS_CLR;
        else if (cmd_arr)
          state_next = WPSS_ARRAY;
      end
      WPSS_SETUP:  if (tick_end && phase_reg) state_next = WPSS_DATA;
      WPSS_DATA:   if (tick_end && phase_reg) state_next = WPSS_POLL;
      WPSS_POLL:   if (tick_end) state_next = WPSS_CHECK;
      WPSS_CHECK: begin
        if (rd_ready)
          state_next = WPSS_IDLE;
        else if (wait_reg >= TIMEOUT)
          state_next = WPSS_IDLE;
        else
          state_next = WPSS_GAP;
      end
      WPSS_GAP:    if (tick_end) state_next = WPSS_POLL;
      WPSS_CLR:    if (tick_end && phase_reg) state_next = WPSS_IDLE;
      WPSS_ARRAY:  if (tick_end && phase_reg) state_next = WPSS_IDLE;
      WPSS_HOLD:   state_next = WPSS_IDLE;
      default:     state_next = WPSS_IDLE;
    endcase
  end

  wire entering = (state_next != state_reg);
  wire is_wr    = (state_reg == WPSS_SETUP) | (state_reg == WPSS_DATA)
                | (state_reg == WPSS_CLR) | (state_reg == WPSS_ARRAY);
  wire [7:0] tick_load =
      (state_next == WPSS_POLL) ? cyc8(RD_CYC) :
      (state_next == WPSS_GAP)  ? cyc8(WE_HIGH_CYC) : cyc8(WE_LOW_CYC);
  // Setup carries 40h or 42h; data cycle carries the word
  wire [DATA_W-1:0] cmd_code = bitalt_reg ? DATA_W'(`WPSS_CMD_BITALT) : DATA_W'(`WPSS_CMD_PROG);
  wire [DATA_W-1:0] wr_val =
      (state_reg == WPSS_SETUP) ? cmd_code :
      (state_reg == WPSS_DATA)  ? data_reg :
      (state_reg == WPSS_CLR)   ? DATA_W'(`WPSS_CMD_CLEAR_SR) : DATA_W'(`WPSS_CMD_READ_ARRAY);
  wire done_ok  = (state_reg == WPSS_CHECK) & rd_ready;
  wire done_tmo = (state_reg == WPSS_CHECK) & ~rd_ready & (wait_reg >= TIMEOUT);
  // Error bits accumulate in the device, so a one-time check after a series is fine
  wire rd_err   = rd_sr[`WPSS_SR_SUPPLY_ERR] | rd_sr[`WPSS_SR_WRITE_ERR] | rd_sr[`WPSS_SR_LOCKED];
  wire [2:0] ev = {cmd_go & go_block, done_ok & rd_err, done_ok | done_tmo};

  // ----------------------------------------
  // Sequencer registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= WPSS_IDLE;
      tick_reg  <= 8'h00;
      phase_reg <= 1'b0;
      wait_reg  <= 32'h0;
    end else if (clk_en) begin
      state_reg <= state_next;
      if (entering) begin
        tick_reg  <= tick_load;
        phase_reg <= 1'b0;
      end else if (!tick_end) begin
        tick_reg <= tick_reg - 8'h01;
      end else if (is_wr && !phase_reg) begin
        // Second half of a write: strobe high for pulse width high
        tick_reg  <= cyc8(WE_HIGH_CYC);
        phase_reg <= 1'b1;
      end
      // Bounds the wait on ready; a word takes 120 us at most nominally
      if (state_reg == WPSS_DATA)
        wait_reg <= 32'h0;
      else if (state_reg == WPSS_CHECK)
        wait_reg <= wait_reg + 32'(RD_CYC + WE_HIGH_CYC + 1);
    end
  end

  // ----------------------------------------
  // Pin drivers and input synchroniser
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pins_reg  <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0, dq_out: '0, dq_oe: 1'b0};
      dq_s1_reg <= '0;
      dq_s2_reg <= '0;
    end else if (clk_en) begin
      dq_s1_reg <= mem_dq_in;
      dq_s2_reg <= dq_s1_reg;
      pins_reg.addr   <= 23'(addr_reg);
      pins_reg.dq_out <= 16'(wr_val);
      pins_reg.dq_oe  <= is_wr & ~entering;
      pins_reg.ce_n   <= ~((is_wr | state_reg == WPSS_POLL) & ~entering);
      pins_reg.we_n   <= ~(is_wr & ~phase_reg & ~entering);
      // Every poll is a fresh read cycle so status is updated
      pins_reg.oe_n   <= ~((state_reg == WPSS_POLL) & ~entering);
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_reg     <= '0;
      data_reg     <= '0;
      bitalt_reg   <= 1'b0;
      dev_sr_reg   <= `WPSS_STS_RESET;
      stat_reg     <= `WPSS_STS_RESET;
      irq_stat_reg <= 3'h0;
      irq_mask_reg <= 3'h0;
      busy_reg     <= 1'b0;
      timeout_reg  <= 1'b0;
      rdata_reg    <= 32'h0;
      wait_n_reg   <= 1'b0;
      irq_reg      <= 1'b0;
    end else if (clk_en) begin
      wait_n_reg <= acc;
      if (acc)
        rdata_reg <= rmux;
      if (wr_addr)
        addr_reg <= ADDR_W'(avs_writedata);
      if (wr_data)
        data_reg <= DATA_W'(avs_writedata);
      if (cmd_go && !go_block)
        bitalt_reg <= avs_writedata[`WPSS_CTRL_BITALT];
      if (wr_imsk)
        irq_mask_reg <= avs_writedata[2:0];
      busy_reg <= (state_next != WPSS_IDLE);
      if (cmd_go && !go_block)
        timeout_reg <= 1'b0;
      else if (done_tmo)
        timeout_reg <= 1'b1;
      // Device's error bits are sticky until its clear command
      if (state_reg == WPSS_CLR && state_next == WPSS_IDLE)
        dev_sr_reg <= `WPSS_STS_RESET;
      else if (done_ok)
        dev_sr_reg <= dev_sr_reg | rd_sr;
      if (state_reg == WPSS_CHECK)
        stat_reg <= rd_sr;
      // Set wins over a write-one clear
      irq_stat_reg <= (irq_stat_reg & ~(wr_ist ? avs_writedata[2:0] : 3'h0)) | ev;
      irq_reg      <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = ~wait_n_reg;
  assign irq             = irq_reg;
  assign mem_ce_n        = pins_reg.ce_n;
  assign mem_we_n        = pins_reg.we_n;
  assign mem_oe_n        = pins_reg.oe_n;
  assign mem_addr        = ADDR_W'(pins_reg.addr);
  assign mem_dq_out      = DATA_W'(pins_reg.dq_out);
  assign mem_dq_oe       = pins_reg.dq_oe;

endmodule : wpss_host

// file: wpss_map.svh
// Constants of the word program host controller: command codes, register offsets, fields, timing.
// Assumes inclusion by the package, the controller and the bench.
`ifndef WPSS_MAP_SVH
`define WPSS_MAP_SVH

// ----------------------------------------
// Device command codes
// ----------------------------------------
`define WPSS_CMD_PROG        16'h0040
`define WPSS_CMD_BITALT      16'h0042
`define WPSS_CMD_READ_ARRAY  16'h00FF
`define WPSS_CMD_CLEAR_SR    16'h0050

// ----------------------------------------
// Device status bit positions
// ----------------------------------------
`define WPSS_SR_READY        7
`define WPSS_SR_WRITE_ERR    4
`define WPSS_SR_SUPPLY_ERR   3
`define WPSS_SR_LOCKED       1

// ----------------------------------------
// Host register word offsets
// ----------------------------------------
`define WPSS_OFF_CTRL        4'h0
`define WPSS_OFF_ADDR        4'h1
`define WPSS_OFF_DATA        4'h2
`define WPSS_OFF_STAT        4'h3
`define WPSS_OFF_IRQ_STAT    4'h4
`define WPSS_OFF_IRQ_MASK    4'h5
`define WPSS_OFF_DEV_SR      4'h6

// ----------------------------------------
// Control register command field (pulse bits; BITALT is written together with GO)
// ----------------------------------------
`define WPSS_CTRL_GO         0
`define WPSS_CTRL_BITALT     1
`define WPSS_CTRL_CLEAR      2
`define WPSS_CTRL_ARRAY      3

// ----------------------------------------
// Interrupt bits
// ----------------------------------------
`define WPSS_IRQ_DONE        0
`define WPSS_IRQ_ERR         1
`define WPSS_IRQ_REFUSED     2

// ----------------------------------------
// Timing in ns, timeout in clock cycles, clock 200 MHz
// ----------------------------------------
`define WPSS_CLK_NS          5
`define WPSS_WE_LOW_NS       50
`define WPSS_WE_HIGH_NS      20
`define WPSS_RD_NS           135
`define WPSS_TMO_DEF         32'h0000BB80
`define WPSS_STS_RESET       8'h80

`endif

// file: wpss_pkg.sv
// Types of the word program host controller.
// Assumes wpss_map.svh beside it.
`include "wpss_map.svh"
package wpss_pkg;

  typedef enum logic [8:0] {
    WPSS_IDLE  = 9'h001,
    WPSS_SETUP = 9'h002,
    WPSS_DATA  = 9'h004,
    WPSS_POLL  = 9'h008,
    WPSS_GAP   = 9'h010,
    WPSS_CLR   = 9'h020,
    WPSS_ARRAY = 9'h040,
    WPSS_CHECK = 9'h080,
    WPSS_HOLD  = 9'h100
  } wpss_state_t;

  typedef struct packed {
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
    logic [22:0] addr;
    logic [15:0] dq_out;
    logic        dq_oe;
  } wpss_pins_t;

  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } wpss_avreq_t;

endpackage : wpss_pkg

// file: wpss_tb.sv
// Self-checking bench for the word program host controller.
// Assumes the memory model and the bound port checker.
`timescale 1ns/100ps
`include "wpss_map.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; $display("[ERR] %s exp=%0h got=%0h", nm, e, g); end end
module tb;
  import wpss_pkg::*;
  logic        ref_clk, sys_rst, avs_read, avs_write, irq, avs_waitrequest;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic        vpp_bad, lock, wfail, arr_mode;
  logic [15:0] dq_in, scode, wdata;
  logic [22:0] waddr;
  logic [7:0]  sr;
  wire wpss_pins_t pins;
  int          nprog, miscompares, cmp_count, k;
  wpss_host #(.TIMEOUT(32'h000007D0)) i_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .mem_ce_n(pins.ce_n), .mem_we_n(pins.we_n), .mem_oe_n(pins.oe_n), .mem_addr(pins.addr),
    .mem_dq_out(pins.dq_out), .mem_dq_oe(pins.dq_oe), .mem_dq_in(dq_in));
  wpss_dev_model #(.PROG_NS(2000)) i_mem (
    .pins(pins), .dq_in(dq_in), .vpp_bad(vpp_bad), .lock(lock), .wfail(wfail), .sr(sr),
    .scode(scode), .wdata(wdata), .waddr(waddr), .arr_mode(arr_mode), .nprog(nprog));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  // Holds the request until waitrequest is sampled low; read data taken there
  task automatic av(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin miscompares++; stop_test(); end
  endtask : av
  task automatic wait_idle;
    int j;
    j = 0;
    do begin
      av(`WPSS_OFF_CTRL, 1'b0, 32'h0);
      j++;
    end while (rd[0] !== 1'b0 && j < 500);
    if (rd[0] !== 1'b0) begin miscompares++; stop_test(); end
  endtask : wait_idle
  task automatic word(input logic [31:0] ctl, input logic [31:0] a, input logic [31:0] d);
    av(`WPSS_OFF_ADDR, 1'b1, a);
    av(`WPSS_OFF_DATA, 1'b1, d);
    av(`WPSS_OFF_CTRL, 1'b1, ctl);
    wait_idle();
  endtask : word
  task automatic cmd(input logic [31:0] ctl);
    av(`WPSS_OFF_CTRL, 1'b1, ctl);
    wait_idle();
  endtask : cmd
  initial begin
    sys_rst = 1'b1;
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    {vpp_bad, lock, wfail} = 3'h0;
    miscompares = 0;
    cmp_count = 0;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    av(4'hF, 1'b0, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    av(`WPSS_OFF_IRQ_MASK, 1'b1, 32'h7);
    av(`WPSS_OFF_ADDR, 1'b1, 32'h12345);
    av(`WPSS_OFF_DATA, 1'b1, 32'hA5C3);
    av(`WPSS_OFF_CTRL, 1'b1, 32'h1);
    for (k = 0; k < 400 && nprog == 0; k++) @(posedge ref_clk);
    `CHK("ready_busy", 1'b0, sr[7])
    av(`WPSS_OFF_CTRL, 1'b0, 32'h0);
    `CHK("ctrl_busy", 1'b1, rd[0])
    wait_idle();
    `CHK("setup", 16'h0040, scode)
    `CHK("addr", 23'h12345, waddr)
    `CHK("data", 16'hA5C3, wdata)
    av(`WPSS_OFF_STAT, 1'b0, 32'h0);
    `CHK("stat", 9'h080, rd[8:0])
    av(`WPSS_OFF_IRQ_STAT, 1'b0, 32'h0);
    `CHK("irq_done", 3'h1, rd[2:0])
    `CHK("irq_pin", 1'b1, irq)
    av(`WPSS_OFF_IRQ_STAT, 1'b1, 32'h7);
    av(`WPSS_OFF_IRQ_MASK, 1'b1, 32'h0);
    word(32'h3, 32'h00200, 32'h0F0F);
    `CHK("bitalt", 16'h0042, scode)
    `CHK("irq_mask", 1'b0, irq)
    av(`WPSS_OFF_IRQ_STAT, 1'b1, 32'h7);
    av(`WPSS_OFF_IRQ_MASK, 1'b1, 32'h7);
    wfail <= 1'b1;
    word(32'h1, 32'h00300, 32'h1111);
    wfail <= 1'b0;
    av(`WPSS_OFF_DEV_SR, 1'b0, 32'h0);
    `CHK("wr_err", 1'b1, rd[4])
    av(`WPSS_OFF_IRQ_STAT, 1'b0, 32'h0);
    `CHK("irq_err", 3'h3, rd[2:0])
    word(32'h1, 32'h00301, 32'h2222);
    `CHK("refused", 3, nprog)
    av(`WPSS_OFF_IRQ_STAT, 1'b0, 32'h0);
    `CHK("irq_refused", 3'h7, rd[2:0])
    cmd(32'h8);
    `CHK("array", 1'b1, arr_mode)
    `CHK("sticky", 1'b1, sr[4])
    cmd(32'h4);
    `CHK("cleared", 8'h80, sr)
    lock <= 1'b1;
    word(32'h1, 32'h00400, 32'h3333);
    lock <= 1'b0;
    `CHK("lock_flag", 1'b1, sr[1])
    `CHK("lock_abort", 3, nprog)
    cmd(32'h4);
    vpp_bad <= 1'b1;
    word(32'h1, 32'h00500, 32'h4444);
    vpp_bad <= 1'b0;
    av(`WPSS_OFF_DEV_SR, 1'b0, 32'h0);
    `CHK("supply", 1'b1, rd[3])
    `CHK("supply_abort", 3, nprog)
    cmd(32'h4);
    word(32'h1, 32'h00500, 32'h4444);
    `CHK("retry", 4, nprog)
    stop_test();
  end
endmodule : tb
